// File: logic/rtc_timer.sv
/*
  two 8-bit programmable timers of a real-time clock: prescaler from the
  crystal enable, timer A watchdog/countdown with flags and the first interrupt
  pin, timer B clock and pulse-width settings.
  assumes the serial interface decodes each register access into one-cycle
  strobes on clk_in, and that the control bits living in other registers
  arrive as plain levels.
*/
`timescale 1ns/1ps
`include "rtc_timer_map.svh"

// Overview of operation
// [R01] timer A source field picks 4096, 64, 1, 1/60 or 1/3600 Hz; reset 111
// [R02] timer B source field decodes identically; reset 111
// [R03] timer B pulse-width field bits 6:4 gives 46.875 to 218.750 ms; reset 000
// [R04] value register n sets period n over source frequency; timer B value is only stored and read back
// [R05] function field 01 is countdown, 10 is watchdog
// [R06] watchdog counts down; at count 1 next tick sets watchdog flag
// [R07] watchdog flag raises interrupt only when its enable is 1
// [R08] watchdog interrupt is pulse or level per interrupt-mode bit
// [R09] watchdog never reloads; only a software write restarts it
// [R10] watchdog: nonzero write clears flag and interrupt, starts counting
// [R11] watchdog: zero write clears flag and interrupt, stops counting
// [R12] watchdog flag read-only; reading status register 01h clears it
// [R13] countdown: at count 1 next tick sets flag, reloads n, continues
// [R14] countdown expiry with enable 1 asserts the first interrupt pin
// [R15] function field 00 or 11 disables timer A
// [R16] interrupt-mode bit 0 means level, 1 means pulse
// [R17] countdown flag stays set until host clears it
// [R18] countdown with count zero stands still
// [R19] unused bits of clock registers read zero, writes ignored
// [R20] all source clocks are divided from the crystal oscillator
module rtc_timer (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        osc_tick_in,
  input  wire logic [7:0]                  reg_addr_in,
  input  wire rtc_timer_pkg::rtc_byte_type reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic [1:0]                  timer_a_function_sel_in,
  input  wire logic                        timer_a_irq_pulse_mode_in,
  input  wire logic                        watchdog_irq_enable_in,
  input  wire logic                        countdown_a_irq_enable_in,
  input  wire logic                        countdown_a_flag_clear_in,
  output logic [7:0]                       reg_rdata_out,
  output logic                             watchdog_expired_flag_out,
  output logic                             countdown_a_expired_flag_out,
  output logic                             irq_pin_first_n_out,
  output logic                             irq_pin_first_oe_out,
  output logic                             timer_b_src_tick_out,
  output logic [9:0]                       timer_b_pulse_ticks_out
);
  import rtc_timer_pkg::*;

  logic [14:0] pre_r;
  logic [14:0] pre_nxt;
  logic [5:0]  sec_r;
  logic [5:0]  sec_nxt;
  logic [5:0]  min_r;
  logic [5:0]  min_nxt;
  logic [4:0]  src_tick;

  logic [2:0]  a_src_r;
  logic [2:0]  a_src_nxt;
  logic [2:0]  b_src_r;
  logic [2:0]  b_src_nxt;
  logic [2:0]  b_pw_r;
  logic [2:0]  b_pw_nxt;
  logic [7:0]  a_reload_r;
  logic [7:0]  a_reload_nxt;
  logic [7:0]  a_count_r;
  logic [7:0]  a_count_nxt;
  logic [7:0]  b_value_r;
  logic [7:0]  b_value_nxt;
  logic        wd_flag_r;
  logic        wd_flag_nxt;
  logic        cd_flag_r;
  logic        cd_flag_nxt;
  logic        pulse_r;
  logic        pulse_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        b_tick_r;
  logic        b_tick_nxt;
  logic [9:0]  b_pw_ticks_r;
  logic [9:0]  b_pw_ticks_nxt;

  // codes 100, 110, 111 (and the unlisted 101) all mean one hour
  function automatic rtc_src_type decode_src(input logic [2:0] code);
    rtc_src_type s;
    s = RTC_SRC_1HOUR;
    unique case (code)
      3'h0:    s = RTC_SRC_4096HZ;
      3'h1:    s = RTC_SRC_64HZ;
      3'h2:    s = RTC_SRC_1HZ;
      3'h3:    s = RTC_SRC_1MIN;
      default: s = RTC_SRC_1HOUR;
    endcase
    return s;
  endfunction : decode_src

  // prescaler chain: 4096 Hz, 64 Hz, 1 Hz, 1/60 Hz, 1/3600 Hz enables
  always_comb begin
    pre_nxt = pre_r;
    sec_nxt = sec_r;
    min_nxt = min_r;
    src_tick[0] = osc_tick_in && ((pre_r & `RTC_PRE_4096_MASK) == `RTC_PRE_4096_MASK); // [R20]
    src_tick[1] = osc_tick_in && ((pre_r & `RTC_PRE_64_MASK) == `RTC_PRE_64_MASK); // [R20]
    src_tick[2] = osc_tick_in && (pre_r == `RTC_PRE_MAX); // [R20]
    src_tick[3] = src_tick[2] && (sec_r == `RTC_SEC_LAST);
    src_tick[4] = src_tick[3] && (min_r == `RTC_MIN_LAST);
    if (osc_tick_in) begin
      pre_nxt = pre_r + 15'h0001;
    end
    if (src_tick[2]) begin
      sec_nxt = (sec_r == `RTC_SEC_LAST) ? 6'h00 : sec_r + 6'h01;
    end
    if (src_tick[3]) begin
      min_nxt = (min_r == `RTC_MIN_LAST) ? 6'h00 : min_r + 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_r <= 15'h0000;
      sec_r <= 6'h00;
      min_r <= 6'h00;
    end else begin
      pre_r <= pre_nxt;
      sec_r <= sec_nxt;
      min_r <= min_nxt;
    end
  end

  // registers, timer A engine, interrupt pin
  always_comb begin
    logic        a_tick;
    logic        rd_status;
    logic        wd_expire;
    logic        cd_expire;
    logic        level;
    rtc_func_type fn;
    a_tick    = src_tick[decode_src(a_src_r)]; // [R01]
    fn        = rtc_func_type'(timer_a_function_sel_in); // [R05]
    level     = 1'b0;
    rd_status = reg_rd_in && (reg_addr_in == `RTC_OFS_CTRL_STATUS);
    wd_expire = 1'b0;
    cd_expire = 1'b0;
    a_src_nxt  = a_src_r;
    b_src_nxt  = b_src_r;
    b_pw_nxt   = b_pw_r;
    a_reload_nxt = a_reload_r;
    a_count_nxt  = a_count_r;
    b_value_nxt  = b_value_r;
    wd_flag_nxt  = wd_flag_r;
    cd_flag_nxt  = cd_flag_r;
    pulse_nxt    = pulse_r;
    rdata_nxt    = rdata_r;

    unique case (fn)
      RTC_FN_WATCHDOG: begin
        if (a_tick && a_count_r != 8'h00) begin // [R06]
          if (a_count_r == 8'h01) begin
            wd_expire   = 1'b1; // [R06]
            a_count_nxt = 8'h00; // [R09]
          end else begin
            a_count_nxt = a_count_r - 8'h01;
          end
        end
      end
      RTC_FN_COUNTDOWN: begin
        if (a_tick && a_count_r != 8'h00) begin // [R18]
          if (a_count_r == 8'h01) begin
            cd_expire   = 1'b1; // [R13]
            a_count_nxt = a_reload_r; // [R13]
          end else begin
            a_count_nxt = a_count_r - 8'h01; // [R04]
          end
        end
      end
      RTC_FN_OFF_LOW, RTC_FN_OFF_HIGH: begin
        a_count_nxt = a_count_r; // [R15]
      end
    endcase

    // clears first, so an expiry in the same cycle still lands
    if (rd_status) begin
      wd_flag_nxt = 1'b0; // [R12]
      pulse_nxt   = 1'b0; // [R12]
    end
    if (countdown_a_flag_clear_in) begin
      cd_flag_nxt = 1'b0; // [R17]
    end
    if (pulse_r && src_tick[1]) begin
      pulse_nxt = 1'b0;
    end

    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `RTC_OFS_TIMER_A_CLK: begin
          a_src_nxt = reg_wdata_in[`RTC_SRC_MSB:`RTC_SRC_LSB]; // [R19]
        end
        `RTC_OFS_TIMER_A_VALUE: begin
          a_reload_nxt = reg_wdata_in; // [R04]
          a_count_nxt  = reg_wdata_in; // [R10] [R11]
          if (fn == RTC_FN_WATCHDOG) begin
            wd_flag_nxt = 1'b0; // [R10] [R11]
            pulse_nxt   = 1'b0; // [R10] [R11]
          end
        end
        `RTC_OFS_TIMER_B_CLKPULSE: begin
          b_src_nxt = reg_wdata_in[`RTC_SRC_MSB:`RTC_SRC_LSB]; // [R19]
          b_pw_nxt  = reg_wdata_in[`RTC_PW_MSB:`RTC_PW_LSB]; // [R19]
        end
        `RTC_OFS_TIMER_B_VALUE: begin
          b_value_nxt = reg_wdata_in; // [R04]
        end
        default: begin
          b_value_nxt = b_value_r;
        end
      endcase
    end

    // a stale write in the same cycle does not hide an expiry
    if (wd_expire) begin
      wd_flag_nxt = 1'b1; // [R06]
      if (watchdog_irq_enable_in) begin
        pulse_nxt = 1'b1; // [R07]
      end
    end
    if (cd_expire) begin
      cd_flag_nxt = 1'b1; // [R13]
      if (countdown_a_irq_enable_in) begin
        pulse_nxt = 1'b1; // [R14]
      end
    end

    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `RTC_OFS_TIMER_A_CLK:      rdata_nxt = {5'h00, a_src_r}; // [R19]
        `RTC_OFS_TIMER_A_VALUE:    rdata_nxt = a_count_r;
        `RTC_OFS_TIMER_B_CLKPULSE: rdata_nxt = {1'b0, b_pw_r, 1'b0, b_src_r}; // [R19]
        `RTC_OFS_TIMER_B_VALUE:    rdata_nxt = b_value_r;
        default:                   rdata_nxt = 8'h00;
      endcase
    end

    level = (wd_flag_nxt && watchdog_irq_enable_in) || (cd_flag_nxt && countdown_a_irq_enable_in); // [R07] [R14]
    irq_nxt = timer_a_irq_pulse_mode_in ? pulse_nxt : level; // [R08] [R16]

    b_tick_nxt     = src_tick[decode_src(b_src_r)]; // [R02]
    // pulse width in 4096 Hz ticks: 3,4,5,6,8,10,12,14 units of 64
    unique case (b_pw_r)
      3'h0: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h003; // [R03]
      3'h1: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h004;
      3'h2: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h005;
      3'h3: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h006;
      3'h4: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h008;
      3'h5: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h00A;
      3'h6: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h00C;
      3'h7: b_pw_ticks_nxt = `RTC_PW_UNIT_TICKS * 10'h00E; // [R03]
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_src_r      <= `RTC_SRC_RESET; // [R01]
      b_src_r      <= `RTC_SRC_RESET; // [R02]
      b_pw_r       <= `RTC_PW_RESET; // [R03]
      a_reload_r   <= `RTC_VALUE_RESET;
      a_count_r    <= `RTC_VALUE_RESET;
      b_value_r    <= `RTC_VALUE_RESET;
      wd_flag_r    <= 1'b0;
      cd_flag_r    <= 1'b0;
      pulse_r      <= 1'b0;
      rdata_r      <= 8'h00;
      irq_r        <= 1'b0;
      b_tick_r     <= 1'b0;
      // matches width code 000, so no illegal width shows after reset
      b_pw_ticks_r <= `RTC_PW_UNIT_TICKS * 10'h003; // [R03]
    end else begin
      a_src_r      <= a_src_nxt;
      b_src_r      <= b_src_nxt;
      b_pw_r       <= b_pw_nxt;
      a_reload_r   <= a_reload_nxt;
      a_count_r    <= a_count_nxt;
      b_value_r    <= b_value_nxt;
      wd_flag_r    <= wd_flag_nxt;
      cd_flag_r    <= cd_flag_nxt;
      pulse_r      <= pulse_nxt;
      rdata_r      <= rdata_nxt;
      irq_r        <= irq_nxt;
      b_tick_r     <= b_tick_nxt;
      b_pw_ticks_r <= b_pw_ticks_nxt;
    end
  end

  // pin is open drain, active low: only ever pulled down
  assign reg_rdata_out                = rdata_r;
  assign watchdog_expired_flag_out    = wd_flag_r;
  assign countdown_a_expired_flag_out = cd_flag_r;
  assign irq_pin_first_n_out          = 1'b0;
  assign irq_pin_first_oe_out         = irq_r;
  assign timer_b_src_tick_out         = b_tick_r;
  assign timer_b_pulse_ticks_out      = b_pw_ticks_r;

endmodule : rtc_timer

// File: logic/rtc_timer_map.svh
/*
  register offsets, field positions, reset values and prescaler counts of the
  programmable timer block. assumes a single 8-bit register space behind the
  serial register interface of the clock chip.
*/
`ifndef RTC_TIMER_MAP_SVH
`define RTC_TIMER_MAP_SVH

`define RTC_OFS_CTRL_STATUS      8'h01
`define RTC_OFS_TIMER_A_CLK      8'h10
`define RTC_OFS_TIMER_A_VALUE    8'h11
`define RTC_OFS_TIMER_B_CLKPULSE 8'h12
`define RTC_OFS_TIMER_B_VALUE    8'h13

`define RTC_SRC_LSB              0
`define RTC_SRC_MSB              2
`define RTC_PW_LSB               4
`define RTC_PW_MSB               6

`define RTC_SRC_RESET            3'h7
`define RTC_PW_RESET             3'h0
`define RTC_VALUE_RESET          8'h00

`define RTC_PRE_MAX              15'h7FFF
`define RTC_PRE_4096_MASK        15'h0007
`define RTC_PRE_64_MASK          15'h01FF
`define RTC_SEC_LAST             6'h3B
`define RTC_MIN_LAST             6'h3B

`define RTC_PW_UNIT_TICKS        10'h040

`endif

// File: logic/rtc_timer_pkg.sv
/*
  types shared by the programmable timer block.
  assumes the map header is included by the design file that needs numbers.
*/
package rtc_timer_pkg;

  typedef logic [7:0] rtc_byte_type;

  typedef enum logic [1:0] {
    RTC_FN_OFF_LOW  = 2'h0,
    RTC_FN_COUNTDOWN = 2'h1,
    RTC_FN_WATCHDOG  = 2'h2,
    RTC_FN_OFF_HIGH = 2'h3
  } rtc_func_type;

  typedef enum logic [2:0] {
    RTC_SRC_4096HZ,
    RTC_SRC_64HZ,
    RTC_SRC_1HZ,
    RTC_SRC_1MIN,
    RTC_SRC_1HOUR
  } rtc_src_type;

endpackage : rtc_timer_pkg

// File: testbench/rtc_timer_checker.sv
/* assertion checker for the programmable timer block.
   sees only the top ports; bound in below the module. */
`timescale 1ns/1ps
module rtc_timer_checker (
  input logic       clk_in,
  input logic       rst_n_in,
  input logic [7:0] reg_addr_in,
  input logic       reg_wr_in,
  input logic       reg_rd_in,
  input logic [1:0] timer_a_function_sel_in,
  input logic       timer_a_irq_pulse_mode_in,
  input logic       watchdog_irq_enable_in,
  input logic       countdown_a_irq_enable_in,
  input logic       countdown_a_flag_clear_in,
  input logic [7:0] reg_rdata_out,
  input logic       watchdog_expired_flag_out,
  input logic       countdown_a_expired_flag_out,
  input logic       irq_pin_first_oe_out,
  input logic [9:0] timer_b_pulse_ticks_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_A_CLK_UNUSED: assert property (
    reg_rd_in && reg_addr_in == 8'h10 |=> reg_rdata_out[7:3] == 5'h00)
    else $error("unused bits of timer a clock register read nonzero");
  AST_B_CLK_UNUSED: assert property (
    reg_rd_in && reg_addr_in == 8'h12 |=> !reg_rdata_out[7] && !reg_rdata_out[3])
    else $error("unused bits of timer b clock register read nonzero");
  AST_WD_LEVEL_IRQ: assert property (
    $rose(watchdog_expired_flag_out) && watchdog_irq_enable_in && !timer_a_irq_pulse_mode_in |-> irq_pin_first_oe_out)
    else $error("watchdog expiry gave no level interrupt");
  // enables act one cycle late on the registered pin
  AST_NO_IRQ_DISABLED: assert property (
    !$past(watchdog_irq_enable_in) && !$past(countdown_a_irq_enable_in) && !$past(irq_pin_first_oe_out)
    |-> !irq_pin_first_oe_out)
    else $error("interrupt raised with both enables low");
  AST_WD_READ_CLEAR: assert property (
    reg_rd_in && reg_addr_in == 8'h01 && watchdog_expired_flag_out |=> !watchdog_expired_flag_out)
    else $error("status read left watchdog flag set");
  AST_WD_WRITE_CLEAR: assert property (
    reg_wr_in && reg_addr_in == 8'h11 && timer_a_function_sel_in == 2'b10 && watchdog_expired_flag_out
    |=> !watchdog_expired_flag_out)
    else $error("value write left watchdog flag set");
  AST_CD_STICKY: assert property (
    $fell(countdown_a_expired_flag_out) |-> $past(countdown_a_flag_clear_in))
    else $error("countdown flag dropped without a host clear");
  AST_WD_ONLY_MODE: assert property (
    $rose(watchdog_expired_flag_out) |-> $past(timer_a_function_sel_in) == 2'b10)
    else $error("watchdog flag set outside watchdog mode");
  AST_CD_ONLY_MODE: assert property (
    $rose(countdown_a_expired_flag_out) |-> $past(timer_a_function_sel_in) == 2'b01)
    else $error("countdown flag set outside countdown mode");
  AST_B_WIDTH_SET: assert property (
    timer_b_pulse_ticks_out inside {10'h0c0, 10'h100, 10'h140, 10'h180, 10'h200, 10'h280, 10'h300, 10'h380})
    else $error("timer b pulse width outside its table");
endmodule : rtc_timer_checker

bind rtc_timer rtc_timer_checker i_chk (
  .clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
  .timer_a_function_sel_in, .timer_a_irq_pulse_mode_in, .watchdog_irq_enable_in,
  .countdown_a_irq_enable_in, .countdown_a_flag_clear_in, .reg_rdata_out,
  .watchdog_expired_flag_out, .countdown_a_expired_flag_out, .irq_pin_first_oe_out,
  .timer_b_pulse_ticks_out
);

// File: testbench/rtc_timer_tb.sv
/* self-checking bench for the timer block.
   assumes the crystal enable may pulse every clock to keep runs short. */
`timescale 1ns/1ps
module rtc_timer_tb;
  import rtc_timer_pkg::*;
  logic         clk_in, rst_n_in, osc_tick_in, reg_wr_in, reg_rd_in;
  logic [7:0]   reg_addr_in, reg_rdata_out, rv;
  rtc_byte_type reg_wdata_in;
  logic [1:0]   timer_a_function_sel_in;
  logic         timer_a_irq_pulse_mode_in, watchdog_irq_enable_in;
  logic         countdown_a_irq_enable_in, countdown_a_flag_clear_in;
  logic         watchdog_expired_flag_out, countdown_a_expired_flag_out, irq_pin_first_oe_out;
  logic         irq_pin_first_n_out, timer_b_src_tick_out;
  logic [9:0]   timer_b_pulse_ticks_out;
  logic [9:0]   pw [8] = '{10'h0c0, 10'h100, 10'h140, 10'h180, 10'h200, 10'h280, 10'h300, 10'h380};
  int           error_cnt = 0;
  int           checked = 0;
  int           n;

  rtc_timer i_dut (.clk_in, .rst_n_in, .osc_tick_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .timer_a_function_sel_in, .timer_a_irq_pulse_mode_in, .watchdog_irq_enable_in,
    .countdown_a_irq_enable_in, .countdown_a_flag_clear_in, .reg_rdata_out,
    .watchdog_expired_flag_out, .countdown_a_expired_flag_out, .irq_pin_first_n_out,
    .irq_pin_first_oe_out, .timer_b_src_tick_out, .timer_b_pulse_ticks_out);

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    rv = reg_rdata_out;
  endtask : rd

  function logic pick(input int s);
    return s == 0 ? countdown_a_expired_flag_out : s == 1 ? watchdog_expired_flag_out : !irq_pin_first_oe_out;
  endfunction : pick

  // bounded poll; a hang ends the run as a failure
  task wt(input int s, input int lim);
    n = 0;
    while (pick(s) !== 1'b1) begin
      @(negedge clk_in);
      n++;
      if (n > lim) begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask : wt

  task clr;
    @(negedge clk_in);
    countdown_a_flag_clear_in = 1'b1;
    @(negedge clk_in);
    countdown_a_flag_clear_in = 1'b0;
  endtask : clr

  task t_regs;
    rd(8'h10);
    chk(rv, 8'h07);
    rd(8'h12);
    chk(rv, 8'h07);
    chk(timer_b_pulse_ticks_out, pw[0]);
    for (int k = 0; k < 8; k++) begin
      wr(8'h10, {5'h1f, k[2:0]});
      rd(8'h10);
      chk(rv, {5'h00, k[2:0]});
      wr(8'h12, {1'b1, k[2:0], 1'b1, k[2:0]});
      rd(8'h12);
      chk(rv, {1'b0, k[2:0], 1'b0, k[2:0]});
      chk(timer_b_pulse_ticks_out, pw[k]);
    end
    wr(8'h11, 8'ha5);
    rd(8'h11);
    chk(rv, 8'ha5);
    wr(8'h13, 8'h5a);
    rd(8'h13);
    chk(rv, 8'h5a);
    rd(8'h2c);
    chk(rv, 8'h00);
  endtask : t_regs

  // 64 Hz from a crystal enable every clock: two ticks in any 1024 clocks
  task t_btick;
    wr(8'h12, 8'h01);
    n = 0;
    repeat (1024) begin
      @(negedge clk_in);
      n += timer_b_src_tick_out;
    end
    chk(n, 16'h0002);
  endtask : t_btick

  // reload period at n=1: 8 clocks at 4096 Hz, 512 at 64 Hz
  task t_cd;
    timer_a_function_sel_in = 2'b01;
    for (int s = 0; s < 2; s++) begin
      wr(8'h10, {7'h00, s[0]});
      wr(8'h11, 8'h01);
      clr();
      wt(0, 600);
      chk(irq_pin_first_oe_out, 1'b1);
      chk(irq_pin_first_n_out, 1'b0);
      clr();
      chk(countdown_a_expired_flag_out, 1'b0);
      wt(0, 600);
      chk(n + 2, s ? 16'h0200 : 16'h0008);
    end
    // stopped by a zero load, so only the host may drop the flag
    wr(8'h11, 8'h00);
    repeat (600) @(negedge clk_in);
    chk(countdown_a_expired_flag_out, 1'b1);
    clr();
    repeat (600) @(negedge clk_in);
    chk(countdown_a_expired_flag_out, 1'b0);
  endtask : t_cd

  task t_wd;
    timer_a_function_sel_in = 2'b10;
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h03);
    wt(1, 40);
    chk(irq_pin_first_oe_out, 1'b1);
    repeat (40) @(negedge clk_in);
    chk(irq_pin_first_oe_out, 1'b1);
    rd(8'h11);
    chk(rv, 8'h00);
    rd(8'h01);
    chk(watchdog_expired_flag_out, 1'b0);
    chk(irq_pin_first_oe_out, 1'b0);
    wr(8'h11, 8'h02);
    wt(1, 40);
    wr(8'h11, 8'h05);
    chk(watchdog_expired_flag_out, 1'b0);
    wt(1, 60);
    wr(8'h11, 8'h00);
    repeat (40) @(negedge clk_in);
    chk(watchdog_expired_flag_out, 1'b0);
    {watchdog_irq_enable_in, countdown_a_irq_enable_in} = 2'b00;
    wr(8'h11, 8'h01);
    wt(1, 20);
    chk(irq_pin_first_oe_out, 1'b0);
    {watchdog_irq_enable_in, countdown_a_irq_enable_in} = 2'b11;
    timer_a_irq_pulse_mode_in = 1'b1;
    wr(8'h11, 8'h01);
    wt(1, 20);
    chk(irq_pin_first_oe_out, 1'b1);
    wt(2, 600);
    chk(watchdog_expired_flag_out, 1'b1);
  endtask : t_wd

  // off codes freeze the count, so no flag may appear
  task t_off;
    for (int f = 0; f < 4; f += 3) begin
      rd(8'h01);
      timer_a_function_sel_in = f[1:0];
      wr(8'h11, 8'h01);
      repeat (40) @(negedge clk_in);
      chk({watchdog_expired_flag_out, countdown_a_expired_flag_out}, 2'b00);
    end
  endtask : t_off

  initial begin
    {osc_tick_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {timer_a_function_sel_in, timer_a_irq_pulse_mode_in, countdown_a_flag_clear_in} = '0;
    {watchdog_irq_enable_in, countdown_a_irq_enable_in} = 2'b11;
    rst_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    osc_tick_in = 1'b1;
    t_regs();
    t_btick();
    t_cd();
    t_wd();
    t_off();
    wrap_up();
  end
endmodule : rtc_timer_tb
